// >>> hdl/vic_pkg.sv
// Package for the vectored interrupt controller: register map, reset values,
// field positions and the packed carrier of the request presented to the core.
// Assumes a 32-bit Avalon-MM register bus and 22-bit program addresses.
package vic_pkg;
   localparam int ADDR_W = 22;                          // Program address width
   localparam int VNUM_W = 8;                           // Vector number width
   // Register byte offsets
   localparam logic [5:0] OFS_GLOBAL_CTRL = 6'h00;      // global_interrupt_control
   localparam logic [5:0] OFS_STATE_FLAGS = 6'h04;      // interrupt_state_flags
   localparam logic [5:0] OFS_REQ_FLAG    = 6'h08;      // request_flag_regs, write 1 clears
   localparam logic [5:0] OFS_REQ_ENABLE  = 6'h0C;      // request_enable_regs
   localparam logic [5:0] OFS_REQ_PRIO    = 6'h10;      // request_priority_regs
   localparam logic [5:0] OFS_TABLE_BASE  = 6'h14;      // vector_table_base
   localparam logic [5:0] OFS_TABLE_GUARD = 6'h18;      // table_guard_register
   localparam logic [5:0] OFS_VEC_ADDR    = 6'h1C;      // computed_vector_address
   localparam logic [5:0] OFS_ISR_ADDR    = 6'h20;      // service routine address
   // Field positions
   localparam int GC_HIGH_EN   = 0;                     // high_global_enable
   localparam int GC_LOW_EN    = 1;                     // low global enable
   localparam int GC_PRIO_EN   = 5;                     // priority_levels_enable
   localparam int GUARD_BIT    = 0;                     // table_guard_bit
   localparam int SF_IRQ       = 0;                     // Request to core active
   localparam int SF_HIGH      = 1;                     // Request is high level
   localparam int SF_VIOL      = 2;                     // Memory execution violation
   localparam int SF_ONCE      = 3;                     // One-shot guard consumed
   // Values after reset and fixed figures
   localparam logic [ADDR_W-1:0] BASE_RESET   = 22'h000008;
   localparam logic [ADDR_W-1:0] LOW_VEC_OFS  = 22'h000010;  // Eight words of two bytes
   localparam logic [7:0]        GUARD_KEY1   = 8'h55;
   localparam logic [7:0]        GUARD_KEY2   = 8'hAA;
   localparam logic [7:0]        GC_RESET     = 8'h00;
   localparam int                ISR_SHIFT    = 2;

   // Unlock sequence states
   typedef enum logic [2:0]
   {
      VIC_SEQ_IDLE = 3'b001,
      VIC_SEQ_KEY1 = 3'b010,
      VIC_SEQ_OPEN = 3'b100
   } vic_seq_t;

   // Request presented to the core
   typedef struct packed
   {
      logic              irq;
      logic              high;
      logic [VNUM_W-1:0] vec_num;
      logic [ADDR_W-1:0] vec_addr;
   } vic_core_req_t;
endpackage

// >>> hdl/vic_top.sv
// Vectored interrupt controller: request flags, enables, priorities, arbitration,
// vector address generation, guarded table base and the Avalon-MM register slave.
// Assumes request and configuration inputs are asynchronous to CORE_CLK, and the
// core handshake (acknowledge, fetched table entry) runs on CORE_CLK.
`timescale 1ns/10ps

// Operation
// - All enabled pending requests merge into one request line to the core.
// - Arbitrate by user priority level first, then lowest vector number.
// - Each source has a flag; set by input, cleared by software or hardware.
// - Per-source enable bit gates the flag into arbitration.
// - Per-source priority bit selects high or low level.
// - Guard bit blocks writes to the table base register.
// - One-shot config limits how often guard bit may toggle after reset.
// - Each table entry is 16 bits over two address locations.
// - Without multi-vector, high vector is base, low vector eight words above.
// - Table base resets to 000008h.
// - Multi-vector address is base plus twice vector number, latched on take.
// - Service routine address is fetched entry shifted left by two.
// - Priority level never alters the computed vector address in multi-vector mode.
// - Entry or routine outside executable memory requests system reset and flags.
// - With one-shot set, after one lock no further unlock until reset.
// - Guard bit changes only on the write right after 55h then AAh.
// - Base writes take effect only with high global enable clear and guard clear.
module vic_top #(
   parameter int                        NSRC      = 8,              // Number of sources
   parameter logic [NSRC-1:0]           HW_CLEAR  = '0,             // Sources cleared by hardware
   parameter logic [vic_pkg::ADDR_W-1:0] EXEC_TOP = 22'h00FFFF     // Last executable address
)(
   input  wire logic                         CORE_CLK,              // 250 MHz clock
   input  wire logic                         RST_N,                 // Synchronous reset, active low
   input  wire logic [5:0]                   AVS_ADDRESS,           // Byte address
   input  wire logic                         AVS_READ,              // Read request
   input  wire logic                         AVS_WRITE,             // Write request
   input  wire logic [31:0]                  AVS_WRITEDATA,         // Write data
   input  wire logic [3:0]                   AVS_BYTEENABLE,        // Byte lanes
   output logic      [31:0]                  AVS_READDATA,          // Read data
   output logic                              AVS_WAITREQUEST,       // Slave stall
   input  wire logic [NSRC-1:0]              REQ_IN,                // Peripheral request lines
   input  wire logic                         CFG_MULTI_VECTOR,      // multi_vector_enable
   input  wire logic                         CFG_ONE_SHOT,          // one_shot_guard_config
   input  wire logic                         CPU_ACK,               // Core takes the request
   input  wire logic                         CPU_ENTRY_VALID,       // Table entry fetched
   input  wire logic [15:0]                  CPU_ENTRY,             // Fetched table entry
   output logic                              CPU_IRQ,               // Single request to core
   output logic                              CPU_IRQ_HIGH,          // Request is high level
   output logic [vic_pkg::ADDR_W-1:0]        CPU_VEC_ADDR,          // Vector fetch address
   output logic [vic_pkg::ADDR_W-1:0]        CPU_ISR_ADDR,          // Service routine address
   output logic                              SYS_RESET_REQ,         // One-cycle system reset request
   output logic                              MEM_VIOL                // Execution violation flag
);
   logic [NSRC-1:0]             req_s1_q, req_s2_q;
   logic [1:0]                  cfg_s1_q, cfg_s2_q;
   logic [NSRC-1:0]             flag_q, enable_q, prio_q;
   logic [7:0]                  gctrl_q;
   logic [vic_pkg::ADDR_W-1:0]  base_q, vec_addr_q, isr_q;
   logic                        guard_q, once_q, viol_q, rst_req_q;
   vic_pkg::vic_seq_t           seq_q;
   vic_pkg::vic_core_req_t      core_q, core_d;
   logic                        wait_q;
   logic [31:0]                 rdata_q, rdata_d;
   logic                        wr_go, mvec, priority_levels_enable;
   logic [NSRC-1:0]             pend, pend_hi, pend_lo, sw_clr;
   logic [vic_pkg::VNUM_W-1:0]  num_hi, num_lo, num_sel;
   logic                        any_hi, any_lo;
   logic [vic_pkg::ADDR_W-1:0]  entry_addr, isr_d;

   // Lowest set index wins; this is the fixed table order, no scanning of sources
   function automatic logic [vic_pkg::VNUM_W-1:0] first_set(input logic [NSRC-1:0] v);
      logic [vic_pkg::VNUM_W-1:0] r;
      r = '0;
      for (int i = NSRC - 1; i >= 0; i--)
      begin
         if (v[i])
            r = vic_pkg::VNUM_W'(i);
      end
      return r;
   endfunction

   // Two-stage synchronisers for pins and configuration straps
   always_ff @(posedge CORE_CLK)
   begin
      if (!RST_N)
      begin
         req_s1_q <= '0;
         req_s2_q <= '0;
         cfg_s1_q <= 2'h0;
         cfg_s2_q <= 2'h0;
      end
      else
      begin
         req_s1_q <= REQ_IN;
         req_s2_q <= req_s1_q;
         cfg_s1_q <= {CFG_ONE_SHOT, CFG_MULTI_VECTOR};
         cfg_s2_q <= cfg_s1_q;
      end
   end
   assign mvec = cfg_s2_q[0];
   assign priority_levels_enable = gctrl_q[vic_pkg::GC_PRIO_EN];

   // A write completes at the edge where waitrequest is seen low
   assign wr_go  = AVS_WRITE && !wait_q;
   assign sw_clr = (wr_go && AVS_ADDRESS == vic_pkg::OFS_REQ_FLAG) ? AVS_WRITEDATA[NSRC-1:0] : '0;

   // Request flags, one per source
   genvar g;
   generate
      for (g = 0; g < NSRC; g++)
      begin : g_flag
         always_ff @(posedge CORE_CLK)
         begin
            if (!RST_N)
               flag_q[g] <= 1'b0;
            else if (HW_CLEAR[g])
               flag_q[g] <= req_s2_q[g];
            else if (req_s2_q[g])
               flag_q[g] <= 1'b1;
            else if (sw_clr[g])
               flag_q[g] <= 1'b0;
         end
      end
   endgenerate

   // Software-written control registers; base write is gated by the guard
   always_ff @(posedge CORE_CLK)
   begin
      if (!RST_N)
      begin
         enable_q <= '0;
         prio_q   <= '0;
         gctrl_q  <= vic_pkg::GC_RESET;
         base_q   <= vic_pkg::BASE_RESET;
      end
      else if (wr_go)
      begin
         case (AVS_ADDRESS)
            vic_pkg::OFS_REQ_ENABLE:
               enable_q <= AVS_WRITEDATA[NSRC-1:0];
            vic_pkg::OFS_REQ_PRIO:
               prio_q <= AVS_WRITEDATA[NSRC-1:0];
            vic_pkg::OFS_GLOBAL_CTRL:
               if (AVS_BYTEENABLE[0])
                  gctrl_q <= AVS_WRITEDATA[7:0];
            vic_pkg::OFS_TABLE_BASE:
               if (!guard_q && !gctrl_q[vic_pkg::GC_HIGH_EN])
                  base_q <= AVS_WRITEDATA[vic_pkg::ADDR_W-1:0];
            default:
               ;
         endcase
      end
   end

   // Guard sequence: 55h, AAh, then the very next bus write may change the bit.
   // Any other write in between breaks the sequence, so stray code cannot unlock.
   always_ff @(posedge CORE_CLK)
   begin
      if (!RST_N)
      begin
         seq_q   <= vic_pkg::VIC_SEQ_IDLE;
         guard_q <= 1'b0;
         once_q  <= 1'b0;
      end
      else if (wr_go)
      begin
         seq_q <= vic_pkg::VIC_SEQ_IDLE;
         if (AVS_ADDRESS == vic_pkg::OFS_TABLE_GUARD)
         begin
            case (seq_q)
               vic_pkg::VIC_SEQ_IDLE:
                  if (AVS_WRITEDATA[7:0] == vic_pkg::GUARD_KEY1)
                     seq_q <= vic_pkg::VIC_SEQ_KEY1;
               vic_pkg::VIC_SEQ_KEY1:
                  if (AVS_WRITEDATA[7:0] == vic_pkg::GUARD_KEY2)
                     seq_q <= vic_pkg::VIC_SEQ_OPEN;
               vic_pkg::VIC_SEQ_OPEN:
               begin
                  if (AVS_WRITEDATA[vic_pkg::GUARD_BIT])
                  begin
                     guard_q <= 1'b1;
                     once_q  <= 1'b1;
                  end
                  else if (!(cfg_s2_q[1] && once_q))
                     guard_q <= 1'b0;
               end
               default:
                  seq_q <= vic_pkg::VIC_SEQ_IDLE;
            endcase
         end
      end
   end

   // Arbitration: high level beats low, then fixed vector order
   always_comb
   begin
      pend    = flag_q & enable_q;
      pend_hi = priority_levels_enable ? (pend & prio_q) : pend;
      pend_lo = priority_levels_enable ? (pend & ~prio_q) : '0;
      any_hi  = gctrl_q[vic_pkg::GC_HIGH_EN] && (pend_hi != '0);
      any_lo  = gctrl_q[vic_pkg::GC_HIGH_EN] && gctrl_q[vic_pkg::GC_LOW_EN] && (pend_lo != '0);
      num_hi  = first_set(pend_hi);
      num_lo  = first_set(pend_lo);
      num_sel = any_hi ? num_hi : num_lo;
      core_d.irq     = any_hi || any_lo;
      core_d.high    = any_hi;
      core_d.vec_num = num_sel;
      // Address depends only on mode and number, never on priority in multi-vector
      if (mvec)
         core_d.vec_addr = base_q + {num_sel, 1'b0};
      else if (priority_levels_enable && !any_hi)
         core_d.vec_addr = base_q + vic_pkg::LOW_VEC_OFS;
      else
         core_d.vec_addr = base_q;
   end

   // Request presented to the core, registered
   always_ff @(posedge CORE_CLK)
   begin
      if (!RST_N)
         core_q <= '0;
      else
         core_q <= core_d;
   end

   // Vector address latched when the core takes the interrupt
   always_ff @(posedge CORE_CLK)
   begin
      if (!RST_N)
         vec_addr_q <= vic_pkg::BASE_RESET;
      else if (CPU_ACK && core_q.irq)
         vec_addr_q <= core_q.vec_addr;
   end

   // In multi-vector mode the fetched entry gives the routine address; out-of-range fetch requests reset
   assign entry_addr = vec_addr_q + 22'h000001;
   assign isr_d      = {6'h00, CPU_ENTRY} << vic_pkg::ISR_SHIFT;
   always_ff @(posedge CORE_CLK)
   begin
      if (!RST_N)
      begin
         isr_q     <= '0;
         rst_req_q <= 1'b0;
      end
      else
      begin
         rst_req_q <= 1'b0;
         if (CPU_ENTRY_VALID && mvec)
         begin
            isr_q <= isr_d;
            if (entry_addr > EXEC_TOP || isr_d > EXEC_TOP)
               rst_req_q <= 1'b1;
         end
      end
   end

   // Violation flag survives our own reset request; cleared by RST_N or by software
   always_ff @(posedge CORE_CLK)
   begin
      if (!RST_N)
         viol_q <= 1'b0;
      else if (rst_req_q)
         viol_q <= 1'b1;
      else if (wr_go && AVS_ADDRESS == vic_pkg::OFS_STATE_FLAGS && AVS_WRITEDATA[vic_pkg::SF_VIOL])
         viol_q <= 1'b0;
   end

   // Read mux; unmapped offsets read zero
   always_comb
   begin
      rdata_d = 32'h0000_0000;
      case (AVS_ADDRESS)
         vic_pkg::OFS_GLOBAL_CTRL: rdata_d[7:0]        = gctrl_q;
         vic_pkg::OFS_STATE_FLAGS:
         begin
            rdata_d[vic_pkg::SF_IRQ]  = core_q.irq;
            rdata_d[vic_pkg::SF_HIGH] = core_q.high;
            rdata_d[vic_pkg::SF_VIOL] = viol_q;
            rdata_d[vic_pkg::SF_ONCE] = once_q;
         end
         vic_pkg::OFS_REQ_FLAG:    rdata_d[NSRC-1:0]   = flag_q;
         vic_pkg::OFS_REQ_ENABLE:  rdata_d[NSRC-1:0]   = enable_q;
         vic_pkg::OFS_REQ_PRIO:    rdata_d[NSRC-1:0]   = prio_q;
         vic_pkg::OFS_TABLE_BASE:  rdata_d[vic_pkg::ADDR_W-1:0] = base_q;
         vic_pkg::OFS_TABLE_GUARD: rdata_d[vic_pkg::GUARD_BIT]  = guard_q;
         vic_pkg::OFS_VEC_ADDR:    rdata_d[vic_pkg::ADDR_W-1:0] = vec_addr_q;
         vic_pkg::OFS_ISR_ADDR:    rdata_d[vic_pkg::ADDR_W-1:0] = isr_q;
         default:                  rdata_d = 32'h0000_0000;
      endcase
   end

   // One wait cycle per access; read data is captured while waitrequest is high
   always_ff @(posedge CORE_CLK)
   begin
      if (!RST_N)
      begin
         wait_q  <= 1'b1;
         rdata_q <= 32'h0000_0000;
      end
      else
      begin
         wait_q <= !((AVS_READ || AVS_WRITE) && wait_q);
         if (AVS_READ && wait_q)
            rdata_q <= rdata_d;
      end
   end

   assign AVS_READDATA    = rdata_q;
   assign AVS_WAITREQUEST = wait_q;
   assign CPU_IRQ         = core_q.irq;
   assign CPU_IRQ_HIGH    = core_q.high;
   assign CPU_VEC_ADDR    = core_q.vec_addr;
   assign CPU_ISR_ADDR    = isr_q;
   assign SYS_RESET_REQ   = rst_req_q;
   assign MEM_VIOL        = viol_q;
endmodule

// >>> test/vic_props.sv
// Checker for the vectored interrupt controller, watching the top ports only.
// Assumes one clock domain and a synchronous active-low reset; bound below.
`timescale 1ns/10ps
module vic_props #(
   parameter int                         NSRC     = 8,           // Number of sources
   parameter logic [vic_pkg::ADDR_W-1:0] EXEC_TOP = 22'h00FFFF   // Last executable address
)(
   input wire logic                         CORE_CLK,            // Clock
   input wire logic                         RST_N,               // Reset, active low
   input wire logic                         AVS_READ,            // Bus read
   input wire logic                         AVS_WRITE,           // Bus write
   input wire logic                         AVS_WAITREQUEST,     // Bus stall
   input wire logic [NSRC-1:0]              REQ_IN,              // Request lines
   input wire logic                         CFG_MULTI_VECTOR,    // Multi-vector config
   input wire logic                         CPU_ENTRY_VALID,     // Entry fetched
   input wire logic [15:0]                  CPU_ENTRY,           // Fetched entry
   input wire logic                         CPU_IRQ,             // Request to core
   input wire logic                         CPU_IRQ_HIGH,        // High level request
   input wire logic                         CPU_ACK,             // Core take
   input wire logic [vic_pkg::ADDR_W-1:0]   CPU_ISR_ADDR,        // Routine address
   input wire logic                         SYS_RESET_REQ,       // Reset request
   input wire logic                         MEM_VIOL             // Violation flag
);
   logic seen_q;
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (!RST_N);
   // Remembers any request since reset; a core request without one is spurious
   always_ff @(posedge CORE_CLK)
   begin
      if (!RST_N)
         seen_q <= 1'b0;
      else if (|REQ_IN)
         seen_q <= 1'b1;
   end
   a_bus_answer_next: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
      else $error("bus answer late");
   a_bus_stall_back: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
      else $error("waitrequest low too long");
   a_quiet_after_reset: assert property ($rose(RST_N) |-> !CPU_IRQ && !SYS_RESET_REQ && !MEM_VIOL)
      else $error("outputs active after reset");
   a_irq_has_cause: assert property (CPU_IRQ |-> seen_q)
      else $error("core request without any request line");
   a_high_needs_irq: assert property (CPU_IRQ_HIGH |-> CPU_IRQ)
      else $error("high level without request");
   a_isr_entry_shift: assert property (CPU_ENTRY_VALID && CFG_MULTI_VECTOR && $past(CFG_MULTI_VECTOR, 5)
      |=> CPU_ISR_ADDR == {4'h0, $past(CPU_ENTRY), 2'h0}) else $error("routine address not entry shifted");
   a_range_reset_req: assert property ($past(CPU_ENTRY_VALID) && CFG_MULTI_VECTOR &&
      $past(CFG_MULTI_VECTOR, 5) && CPU_ISR_ADDR > EXEC_TOP |-> SYS_RESET_REQ) else $error("no reset on bad fetch");
   a_reset_req_cause: assert property (SYS_RESET_REQ |-> $past(CPU_ENTRY_VALID))
      else $error("reset request without fetch");
   a_reset_req_pulse: assert property (SYS_RESET_REQ |=> !SYS_RESET_REQ)
      else $error("reset request longer than one cycle");
   a_viol_flag_set: assert property (SYS_RESET_REQ |=> MEM_VIOL)
      else $error("violation flag not set");
   c_core_take: cover property (CPU_ACK && CPU_IRQ);
   c_high_req: cover property (CPU_IRQ_HIGH);
   c_bad_fetch: cover property (SYS_RESET_REQ);
endmodule

bind vic_top vic_props #(.NSRC(NSRC), .EXEC_TOP(EXEC_TOP)) u_props (.CORE_CLK(CORE_CLK), .RST_N(RST_N),
   .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WAITREQUEST(AVS_WAITREQUEST), .REQ_IN(REQ_IN),
   .CFG_MULTI_VECTOR(CFG_MULTI_VECTOR), .CPU_ENTRY_VALID(CPU_ENTRY_VALID), .CPU_ENTRY(CPU_ENTRY),
   .CPU_IRQ(CPU_IRQ), .CPU_IRQ_HIGH(CPU_IRQ_HIGH), .CPU_ACK(CPU_ACK), .CPU_ISR_ADDR(CPU_ISR_ADDR),
   .SYS_RESET_REQ(SYS_RESET_REQ), .MEM_VIOL(MEM_VIOL));

// >>> test/vic_core_model.sv
// Core model: takes the controller's request and returns a fetched table entry.
// Assumes the controller's clock; the bench sets the entry value and the delay.
`timescale 1ns/10ps
module vic_core_model (
   input  wire logic        clk,        // Core clock
   input  wire logic        rst_n,      // Reset, active low
   input  wire logic        irq,        // Request from controller
   input  wire logic [21:0] vec,        // Vector fetch address
   input  wire logic [15:0] entry_in,   // Entry to return
   input  wire logic [3:0]  delay,      // Extra cycles before the take
   output logic             ack,        // Take pulse
   output logic             vld,        // Entry valid pulse
   output logic [15:0]      entry       // Fetched entry
);
   logic [4:0]  cnt_q;
   logic [21:0] last_q;
   // Each new winning vector is fetched once, so a changed winner gets its own fetch
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         last_q <= 22'h000000;
      else if (cnt_q == 5'h00 && irq && vec != last_q)
         last_q <= vec;
      else if (!irq)
         last_q <= 22'h000000;
   end
   // Fetch timer
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         cnt_q <= 5'h00;
      else if (cnt_q != 5'h00)
         cnt_q <= cnt_q - 5'h01;
      else if (irq && vec != last_q)
         cnt_q <= {1'b0, delay} + 5'h03;
   end
   // Entry toggles outside its valid cycle so a stale value never looks fresh
   always_ff @(posedge clk)
   begin
      ack   <= rst_n && cnt_q == 5'h03;
      vld   <= rst_n && cnt_q == 5'h01;
      entry <= !rst_n ? 16'h0000 : (cnt_q == 5'h01) ? entry_in : ~entry;
   end
endmodule

// >>> test/tb.sv
// Self-checking bench for the vectored interrupt controller with a core model.
// Assumes default parameters: eight sources, last executable address 00FFFFh.
`timescale 1ns/10ps
module tb;
   logic        clk, rst_n, rd_s, wr_s, wait_s, mv, os, ack, vld, irq, irqh, sysr, viol;
   logic [5:0]  adr;
   logic [31:0] wdat, rdata, rdat;
   logic [7:0]  req;
   logic [15:0] ent, ent_v;
   logic [21:0] vec, isr;
   logic [3:0]  dly;
   int          err_total, num_checks;
   always #2 clk = ~clk;
   vic_top u_dut (.CORE_CLK(clk), .RST_N(rst_n), .AVS_ADDRESS(adr), .AVS_READ(rd_s), .AVS_WRITE(wr_s),
      .AVS_WRITEDATA(wdat), .AVS_BYTEENABLE(4'hF), .AVS_READDATA(rdata), .AVS_WAITREQUEST(wait_s), .REQ_IN(req),
      .CFG_MULTI_VECTOR(mv), .CFG_ONE_SHOT(os), .CPU_ACK(ack), .CPU_ENTRY_VALID(vld), .CPU_ENTRY(ent),
      .CPU_IRQ(irq), .CPU_IRQ_HIGH(irqh), .CPU_VEC_ADDR(vec), .CPU_ISR_ADDR(isr), .SYS_RESET_REQ(sysr),
      .MEM_VIOL(viol));
   vic_core_model u_core (.clk(clk), .rst_n(rst_n), .irq(irq), .vec(vec), .entry_in(ent_v), .delay(dly),
      .ack(ack), .vld(vld), .entry(ent));
   task automatic finish_test();
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic fail(input string m);
      err_total++;
      $display("[ERR] %0t %s", $time, m);
   endtask
   task automatic chk_w(input logic [31:0] got, input logic [31:0] exp, input string m);
      num_checks++;
      if (got !== exp) fail(m);
   endtask
   task automatic chk_b(input logic got, input logic exp, input string m);
      num_checks++;
      if (got !== exp) fail(m);
   endtask
   // One bus access: held until waitrequest is sampled low, released right after
   task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      adr <= a; wr_s <= wr; rd_s <= !wr; wdat <= d;
      // Look between edges so the stall is never read in the edge that updates it
      for (n = 0; n < 20 && wait_s !== 1'b0; n++) @(negedge clk);
      @(posedge clk);
      rdat = rdata;
      rd_s <= 1'b0; wr_s <= 1'b0;
      if (n >= 20) begin fail("bus timeout"); finish_test(); end
   endtask
   task automatic wr(input logic [5:0] a, input logic [31:0] d); bus(1'b1, a, d); endtask
   task automatic rchk(input logic [5:0] a, input logic [31:0] m, input logic [31:0] e);
      bus(1'b0, a, 32'h00000000);
      chk_w(rdat & m, e, "register read");
   endtask
   task automatic tick(input int n); repeat (n) @(posedge clk); #1; endtask
   task automatic pulse(input logic [7:0] v); @(posedge clk); req <= v; repeat (2) @(posedge clk); req <= 8'h00; endtask
   // Bounded wait for the core request (0) or the fetched entry (1)
   task automatic wait_for(input int sel);
      int n;
      for (n = 0; n < 60 && !((sel == 0) ? irq === 1'b1 : vld === 1'b1); n++) tick(1);
      if (n >= 60) begin fail("wait timeout"); finish_test(); end
   endtask
   task automatic guard_seq(input logic [31:0] v); wr(6'h18, 32'h00000055); wr(6'h18, 32'h000000AA); wr(6'h18, v); endtask
   task automatic do_reset(); @(posedge clk); rst_n <= 1'b0; repeat (10) @(posedge clk); rst_n <= 1'b1; endtask
   task automatic t_reset();
      rchk(6'h14, 32'hFFFFFFFF, 32'h00000008);
      rchk(6'h18, 32'h00000001, 32'h00000000);
      rchk(6'h24, 32'hFFFFFFFF, 32'h00000000);
   endtask
   task automatic t_legacy();
      wr(6'h00, 32'h00000001); pulse(8'h08); tick(8);
      chk_b(irq, 1'b0, "disabled source reached core");
      wr(6'h0C, 32'h00000008); wait_for(0);
      chk_w({10'h000, vec}, 32'h00000008, "single vector");
      wait_for(1);
      tick(1);
      chk_w({10'h000, isr}, 32'h00000000, "entry used in legacy mode");
      rchk(6'h08, 32'h000000FF, 32'h00000008);
      wr(6'h00, 32'h00000023); tick(2);
      chk_w({10'h000, vec}, 32'h00000018, "low vector");
      chk_b(irqh, 1'b0, "level of low source");
      wr(6'h10, 32'h00000008); tick(2);
      chk_w({10'h000, vec}, 32'h00000008, "high vector");
      chk_b(irqh, 1'b1, "level of high source");
      wr(6'h08, 32'h000000FF); tick(2);
      chk_b(irq, 1'b0, "request after clear");
   endtask
   task automatic t_guard();
      wr(6'h00, 32'h00000000); wr(6'h18, 32'h00000001);
      rchk(6'h18, 32'h00000001, 32'h00000000);
      guard_seq(32'h00000001); rchk(6'h18, 32'h00000001, 32'h00000001);
      wr(6'h14, 32'h00000040); rchk(6'h14, 32'hFFFFFFFF, 32'h00000008);
      guard_seq(32'h00000000); rchk(6'h18, 32'h00000001, 32'h00000000);
      @(posedge clk); os <= 1'b1; tick(4);
      guard_seq(32'h00000001); guard_seq(32'h00000000);
      rchk(6'h18, 32'h00000001, 32'h00000001);
      @(posedge clk); os <= 1'b0; do_reset();
      rchk(6'h18, 32'h00000001, 32'h00000000);
   endtask
   task automatic t_multi();
      @(posedge clk); mv <= 1'b1; ent_v <= 16'h0123; dly <= 4'h0; tick(4);
      wr(6'h14, 32'h00000100); rchk(6'h14, 32'hFFFFFFFF, 32'h00000100);
      wr(6'h00, 32'h00000023); wr(6'h14, 32'h00000200);
      rchk(6'h14, 32'hFFFFFFFF, 32'h00000100);
      wr(6'h10, 32'h00000020); wr(6'h0C, 32'h00000024); pulse(8'h24); wait_for(0);
      chk_w({10'h000, vec}, 32'h0000010A, "high winner vector");
      wait_for(1); tick(1);
      chk_w({10'h000, isr}, 32'h0000048C, "routine address");
      chk_b(sysr, 1'b0, "reset on good fetch");
      rchk(6'h1C, 32'hFFFFFFFF, 32'h0000010A);
      wr(6'h08, 32'h00000020); tick(2);
      chk_w({10'h000, vec}, 32'h00000104, "low source vector");
      wr(6'h10, 32'h00000024); pulse(8'h20); tick(6);
      chk_w({10'h000, vec}, 32'h00000104, "natural order");
      wr(6'h08, 32'h000000FF); tick(2);
   endtask
   task automatic t_viol();
      @(posedge clk); ent_v <= 16'hFFFF; dly <= 4'h5;
      wr(6'h0C, 32'h00000002); pulse(8'h02); wait_for(0);
      chk_w({10'h000, vec}, 32'h00000102, "vector of source one");
      wait_for(1); tick(1);
      chk_b(sysr, 1'b1, "no reset on bad fetch");
      chk_w({10'h000, isr}, 32'h0003FFFC, "routine address");
      tick(1); chk_b(viol, 1'b1, "violation flag");
      rchk(6'h04, 32'h00000004, 32'h00000004);
      wr(6'h04, 32'h00000004); rchk(6'h04, 32'h00000004, 32'h00000000);
   endtask
   initial
   begin
      clk = 1'b0; rst_n = 1'b0; adr = 6'h00; rd_s = 1'b0; wr_s = 1'b0; wdat = 32'h00000000; req = 8'h00;
      mv = 1'b0; os = 1'b0; ent_v = 16'h0040; dly = 4'h0; err_total = 0; num_checks = 0;
      do_reset();
      t_reset();
      t_legacy();
      t_guard();
      t_multi();
      t_viol();
      finish_test();
   end
endmodule
